// ---- rtl/fpc_cfg.svh ----
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH

// Register word indices; the byte address is four times the index.
`define FPC_IDX_CONTROL     10'h0d1
`define FPC_IDX_DATA_WRITE  10'h0d2
`define FPC_IDX_CODE_READ   10'h0d3
`define FPC_IDX_LOCK_STATUS 10'h0d4

// Control register fields.
`define FPC_BUSY_BIT  0
`define FPC_SPACE_LSB 1
`define FPC_SPACE_MSB 2
`define FPC_MAP_BIT   3
`define FPC_KEY_LSB   4
`define FPC_KEY_MSB   7
`define FPC_KEY_ARM   4'h5
`define FPC_KEY_GO    4'ha
`define FPC_CTRL_RESET 8'h00

// Space select encodings.
`define FPC_SPACE_USER 2'h0
`define FPC_SPACE_EXTRA_ROW_SPACE 2'h1
`define FPC_SPACE_SEC  2'h2
`define FPC_SPACE_RSVD 2'h3

// Data write register fields.
`define FPC_DW_DATA_MSB 7
`define FPC_DW_ADDR_LSB 8
`define FPC_DW_ADDR_MSB 23

// Address map of the flash spaces.
`define FPC_EXTRA_ROW_SPACE_BASE 16'hff80
`define FPC_SEC_ADDR  16'h0000
`define FPC_USER_MSB  13
`define FPC_PAGE_LSB  7

// Security byte layout and values.
`define FPC_LOCK_MSB      2
`define FPC_SEC_HI_LSB    3
`define FPC_LOCK_RESET    3'h5
`define FPC_SEC_HI_RESET  5'h1f
`define FPC_ERASED        8'hff
`define FPC_LOCK_STAT_PD  3
`define FPC_LOCK_STAT_VD  4

// Timing of the programming engine.
`define FPC_CLK_NS   10
`define FPC_ERASE_NS 2000
`define FPC_PROG_NS  2000

`endif

// ---- rtl/fpc_pkg.sv ----
package fpc_pkg;

    // Programming engine states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_PROG
    } fpc_state_e;

    // Source of a code-space read.
    typedef enum logic [1:0] {
        SRC_USER,
        SRC_EXTRA_ROW_SPACE,
        SRC_SEC
    } fpc_src_e;

    typedef logic [1:0] fpc_space_t;

endpackage

// ---- rtl/fpc_mem.sv ----
`timescale 1ns/100ps

// Simple dual-port memory with one write port and a registered read port.
module fpc_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             re,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage has no reset, as a real array would not.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data always come from a register.
    always_ff @(posedge clk) begin
        if (re) begin
            rdata <= mem[raddr];
        end
    end

endmodule

// ---- rtl/fpc_top.sv ----
`timescale 1ns/100ps
`include "fpc_cfg.svh"

// Summary of operation
// - Key 5 then A with user space starts user array programming.
// - Key 5 then A with extra row space starts extra row programming.
// - Key 5 then A with security space starts security byte programming.
// - Busy flag in bit 0 is set during programming, cleared at its end.
// - Control 0Ch maps latches and security; data write at 0000h loads it.
// - Space select extra row makes code reads at FF80h-FFFFh hit the row.
// - Space select security makes a code read at 0000h return the byte.
// - Writing 00h unmaps all spaces; software leaves the register clear.
// - Latch map bit routes data writes to latches, else to data memory.
// - Three lock bits give the level; first lock bit blocks programming.
// - Second or third lock bit also blocks parallel verify.
// - Lock bits come out of reset at level 3.
// - Only the parallel port changes lock bits, never software programming.
// - Code reads keep working while programming runs.
// - Space select 11 is reserved and launches nothing.
// - The two key writes must be back to back or the launch aborts.
// - Launch erases only loaded latch locations, then programs them.
module fpc_top #(
    parameter int LATCH_DEPTH = 128,
    parameter int LATCH_AW    = 7,
    parameter int USER_DEPTH  = 16384,
    parameter int USER_AW     = 14,
    parameter int ERASE_CYC   = (`FPC_ERASE_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS,
    parameter int PROG_CYC    = (`FPC_PROG_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             dmem_we,
    output logic      [15:0] dmem_addr,
    output logic      [7:0]  dmem_wdata,
    input  wire logic        pp_lock_load,
    input  wire logic [2:0]  pp_lock_bits,
    output logic             pp_prog_disable,
    output logic             pp_verify_disable
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    logic [7:1]               ctrl;
    logic                     prog_busy;
    logic                     armed;
    fpc_pkg::fpc_state_e      state;
    fpc_pkg::fpc_space_t      prog_space;
    logic [15:0]              cnt;
    logic                     step_valid;
    logic                     step_erase;
    logic [LATCH_AW-1:0]      step_idx;
    logic [LATCH_DEPTH-1:0]   loaded;
    logic [USER_AW-1:LATCH_AW] page;
    logic [2:0]               lock;
    logic [7:`FPC_SEC_HI_LSB] sec_hi;
    logic [7:0]               code_data;
    logic                     rd_pend;
    fpc_pkg::fpc_src_e        rd_src;
    logic                     load_s1;
    logic                     load_s2;
    logic                     load_s3;
    logic [2:0]               bits_s1;
    logic [2:0]               bits_s2;
    logic [7:0]               user_rdata;
    logic [7:0]               extra_row_space_rdata;
    logic [7:0]               latch_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode. A request is taken while waitrequest is high.
    wire        accept    = (avs_read | avs_write) & avs_waitrequest;
    wire [9:0]  idx       = avs_address[11:2];
    wire        wr_ok     = accept & avs_write & avs_byteenable[0];
    wire        ctrl_wr   = wr_ok & (idx == `FPC_IDX_CONTROL);
    wire        dw_wr     = wr_ok & (idx == `FPC_IDX_DATA_WRITE);
    wire        cr_wr     = wr_ok & (idx == `FPC_IDX_CODE_READ);
    wire [3:0]  key       = avs_writedata[`FPC_KEY_MSB:`FPC_KEY_LSB];
    wire [1:0]  wr_space  = avs_writedata[`FPC_SPACE_MSB:`FPC_SPACE_LSB];
    wire [1:0]  space     = ctrl[`FPC_SPACE_MSB:`FPC_SPACE_LSB];
    wire        latch_map = ctrl[`FPC_MAP_BIT];
    wire [15:0] dw_addr   = avs_writedata[`FPC_DW_ADDR_MSB:`FPC_DW_ADDR_LSB];
    wire [7:0]  dw_data   = avs_writedata[`FPC_DW_DATA_MSB:0];
    wire [15:0] cr_addr   = avs_writedata[15:0];
    wire [7:0]  sec_byte  = {sec_hi, lock};
    // The launch needs the arming write right before, a real space and an idle engine.
    wire key_arm = ctrl_wr & (key == `FPC_KEY_ARM);
    wire launch  = ctrl_wr & (key == `FPC_KEY_GO) & armed
                 & (wr_space != `FPC_SPACE_RSVD) & ~prog_busy;
    // Data-space write routing: latches when mapped, plain data memory otherwise.
    wire latch_we = dw_wr & latch_map;
    wire dmem_go  = dw_wr & ~latch_map;

    ////////////////////////////////////////////////////////////////////////////
    // Code read source selection, decided at the request.
    wire is_extra_row_space = (space == `FPC_SPACE_EXTRA_ROW_SPACE) & (cr_addr >= `FPC_EXTRA_ROW_SPACE_BASE);
    wire is_sec  = (space == `FPC_SPACE_SEC) & (cr_addr == `FPC_SEC_ADDR);
    wire fpc_pkg::fpc_src_e next_src = is_extra_row_space ? fpc_pkg::SRC_EXTRA_ROW_SPACE :
                                       is_sec  ? fpc_pkg::SRC_SEC  : fpc_pkg::SRC_USER;

    ////////////////////////////////////////////////////////////////////////////
    // Read data mux for the register bus; unmapped words read zero.
    wire [7:0] ctrl_rd = {ctrl, prog_busy};
    wire [7:0] lock_rd = {3'h0, pp_verify_disable, pp_prog_disable, lock};
    wire [31:0] rd_mux = (idx == `FPC_IDX_CONTROL)     ? {24'h0, ctrl_rd}   :
                         (idx == `FPC_IDX_CODE_READ)   ? {24'h0, code_data} :
                         (idx == `FPC_IDX_LOCK_STATUS) ? {24'h0, lock_rd}   : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Engine datapath: a pipelined walk over the latches.
    wire [LATCH_AW-1:0] walk_idx = cnt[LATCH_AW-1:0];
    wire                walk_re  = (state != fpc_pkg::ST_IDLE) & (cnt < 16'(LATCH_DEPTH));
    wire                step_hit = step_valid & loaded[step_idx];
    wire [7:0]          step_data = step_erase ? `FPC_ERASED : latch_rdata;
    wire user_we = step_hit & (prog_space == `FPC_SPACE_USER);
    wire extra_row_space_we = step_hit & (prog_space == `FPC_SPACE_EXTRA_ROW_SPACE);
    wire sec_we  = step_hit & (prog_space == `FPC_SPACE_SEC) & (step_idx == '0);
    wire [USER_AW-1:0] user_waddr = {page, step_idx};
    wire last_erase = (state == fpc_pkg::ST_ERASE) & (cnt == 16'(ERASE_CYC - 1));
    wire last_prog  = (state == fpc_pkg::ST_PROG) & (cnt == 16'(PROG_CYC - 1));
    wire lock_edge  = load_s2 & ~load_s3;

    ////////////////////////////////////////////////////////////////////////////
    // Memories. Reads of the user array and row use their own port, so
    // code reads go on while the engine writes.
    fpc_mem #(.WIDTH(8), .DEPTH(LATCH_DEPTH), .AW(LATCH_AW)) u_latch (
        .clk   (clk),
        .we    (latch_we),
        .waddr (dw_addr[LATCH_AW-1:0]),
        .wdata (dw_data),
        .re    (walk_re),
        .raddr (walk_idx),
        .rdata (latch_rdata)
    );
    fpc_mem #(.WIDTH(8), .DEPTH(USER_DEPTH), .AW(USER_AW)) u_user (
        .clk   (clk),
        .we    (user_we),
        .waddr (user_waddr),
        .wdata (step_data),
        .re    (cr_wr),
        .raddr (cr_addr[USER_AW-1:0]),
        .rdata (user_rdata)
    );
    fpc_mem #(.WIDTH(8), .DEPTH(LATCH_DEPTH), .AW(LATCH_AW)) u_extra_row_space (
        .clk   (clk),
        .we    (extra_row_space_we),
        .waddr (step_idx),
        .wdata (step_data),
        .re    (cr_wr),
        .raddr (cr_addr[LATCH_AW-1:0]),
        .rdata (extra_row_space_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: each request is answered one cycle after it is taken.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= ~accept;
            if (accept & avs_read) begin
                avs_readdata <= rd_mux;
            end
        end
    end
    // Control register; the busy bit is not stored from the bus.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= 7'(`FPC_CTRL_RESET >> 1);
        end else if (ctrl_wr) begin
            ctrl <= avs_writedata[7:1];
        end
    end
    // Any other bus request between the two key writes disarms the launch.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            armed <= 1'b0;
        end else if (accept) begin
            armed <= key_arm;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Programming engine: erase loaded locations, then program them.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state      <= fpc_pkg::ST_IDLE;
            prog_space <= `FPC_SPACE_USER;
            cnt        <= 16'h0;
        end else begin
            unique case (state)
                fpc_pkg::ST_IDLE: begin
                    cnt <= 16'h0;
                    if (launch) begin
                        state      <= fpc_pkg::ST_ERASE;
                        prog_space <= wr_space;
                    end
                end
                fpc_pkg::ST_ERASE: begin
                    cnt <= last_erase ? 16'h0 : cnt + 16'h1;
                    if (last_erase) begin
                        state <= fpc_pkg::ST_PROG;
                    end
                end
                fpc_pkg::ST_PROG: begin
                    cnt <= cnt + 16'h1;
                    if (last_prog) begin
                        state <= fpc_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end
    // Busy follows the engine, set on launch and cleared on completion.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prog_busy <= 1'b0;
        end else if (launch) begin
            prog_busy <= 1'b1;
        end else if (last_prog) begin
            prog_busy <= 1'b0;
        end
    end
    // One step behind the latch read, when its data are valid.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            step_valid <= 1'b0;
            step_erase <= 1'b0;
            step_idx   <= '0;
        end else begin
            step_valid <= walk_re;
            step_erase <= (state == fpc_pkg::ST_ERASE);
            step_idx   <= walk_idx;
        end
    end
    // Loaded flags and page; a latch write wins over the clear at the end.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loaded <= '0;
            page   <= '0;
        end else begin
            loaded <= (last_prog ? '0 : loaded)
                    | (LATCH_DEPTH'(latch_we) << dw_addr[LATCH_AW-1:0]);
            if (latch_we) begin
                page <= dw_addr[USER_AW-1:LATCH_AW];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Security byte. Software programming touches only the upper bits;
    // the lock bits move only on a strobe from the parallel port.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sec_hi <= `FPC_SEC_HI_RESET;
        end else if (sec_we) begin
            sec_hi <= step_data[7:`FPC_SEC_HI_LSB];
        end
    end
    // Parallel port pins pass two flip-flops before any logic looks at them.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {load_s3, load_s2, load_s1} <= 3'h0;
            {bits_s2, bits_s1}          <= {2{`FPC_LOCK_RESET}};
        end else begin
            {load_s3, load_s2, load_s1} <= {load_s2, load_s1, pp_lock_load};
            {bits_s2, bits_s1}          <= {bits_s1, pp_lock_bits};
        end
    end
    // Lock bits start at level 3; a bit reads 0 when programmed.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lock <= `FPC_LOCK_RESET;
        end else if (lock_edge) begin
            lock <= bits_s2;
        end
    end
    // Protection level decode, registered onto the outputs.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pp_prog_disable   <= 1'b1;
            pp_verify_disable <= 1'b1;
        end else begin
            pp_prog_disable   <= ~&lock;
            pp_verify_disable <= ~lock[1] | ~lock[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Code read path: source is latched with the request, data a cycle later.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_pend   <= 1'b0;
            rd_src    <= fpc_pkg::SRC_USER;
            code_data <= 8'h00;
        end else begin
            rd_pend <= cr_wr;
            if (cr_wr) begin
                rd_src <= next_src;
            end
            if (rd_pend) begin
                unique case (rd_src)
                    fpc_pkg::SRC_USER: code_data <= user_rdata;
                    fpc_pkg::SRC_EXTRA_ROW_SPACE: code_data <= extra_row_space_rdata;
                    fpc_pkg::SRC_SEC:  code_data <= sec_byte;
                    default:           code_data <= user_rdata;
                endcase
            end
        end
    end
    // Plain data memory writes leave as a registered one-cycle strobe.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dmem_we    <= 1'b0;
            dmem_addr  <= 16'h0;
            dmem_wdata <= 8'h00;
        end else begin
            dmem_we <= dmem_go;
            if (dmem_go) begin
                dmem_addr  <= dw_addr;
                dmem_wdata <= dw_data;
            end
        end
    end

endmodule

// ---- tb/fpc_props.sv ----
`timescale 1ns/100ps
`include "fpc_cfg.svh"

////////////////////////////////////////////////////////////
// Watches the register bus, the data-space port and the lock outputs.
module fpc_props #(
    parameter int ERASE_CYC = 200,
    parameter int PROG_CYC  = 200
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [11:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        dmem_we,
    input wire logic [15:0] dmem_addr,
    input wire logic [7:0]  dmem_wdata,
    input wire logic        pp_lock_load,
    input wire logic [2:0]  pp_lock_bits,
    input wire logic        pp_prog_disable,
    input wire logic        pp_verify_disable
);
    logic       armed;
    logic       map;
    logic [6:0] shadow;
    int         cnt;

    // Decode of taken requests; a launch needs the key 5 write just before it.
    wire logic [9:0] idx    = avs_address[11:2];
    wire logic       take   = (avs_read | avs_write) & avs_waitrequest;
    wire logic       wr_ok  = take & avs_write & avs_byteenable[0];
    wire logic       ctl_wr = wr_ok & (idx == `FPC_IDX_CONTROL);
    wire logic       ctl_rd = take & avs_read & (idx == `FPC_IDX_CONTROL);
    wire logic       dw_wr  = wr_ok & (idx == `FPC_IDX_DATA_WRITE);
    wire logic       key_a  = avs_writedata[7:4] == 4'ha;
    wire logic       go     = ctl_wr & armed & key_a & (avs_writedata[2:1] != 2'h3) & (cnt == 0);

    // Busy window estimate; four spare cycles absorb the engine's start and end.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            armed  <= 1'b0;
            map    <= 1'b0;
            shadow <= 7'h00;
            cnt    <= 0;
        end else begin
            if (take)
                armed <= ctl_wr & (avs_writedata[7:4] == 4'h5);
            if (ctl_wr)
                map <= avs_writedata[3];
            if (ctl_wr)
                shadow <= avs_writedata[7:1];
            if (go)
                cnt <= ERASE_CYC + PROG_CYC + 4;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end

    ////////////////////////////////////////////////////////////
    // All checks share one clock and one reset.
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_take;
        take;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    property p_answer;
        s_take |=> s_answer;
    endproperty
    property p_dmem_on;
        dw_wr && !map |=> dmem_we && dmem_addr == $past(avs_writedata[23:8])
            && dmem_wdata == $past(avs_writedata[7:0]);
    endproperty
    property p_dmem_off;
        dmem_we |-> $past(dw_wr && !map);
    endproperty
    property p_busy_on;
        ctl_rd && cnt > 8 |=> avs_readdata[0];
    endproperty
    property p_busy_off;
        ctl_rd && cnt == 0 |=> !avs_readdata[0];
    endproperty
    property p_readback;
        ctl_rd |=> avs_readdata[7:1] == shadow;
    endproperty
    property p_lock_order;
        pp_verify_disable |-> pp_prog_disable;
    endproperty
    property p_lock_hold;
        (!pp_lock_load)[*8] |-> $stable(pp_prog_disable) && $stable(pp_verify_disable);
    endproperty
    property p_reset_lock;
        $rose(nrst) |-> pp_prog_disable && pp_verify_disable;
    endproperty

    a_answer: assert property (p_answer) else $error("bus answer late");
    a_dmem_on: assert property (p_dmem_on) else $error("data write lost");
    a_dmem_off: assert property (p_dmem_off) else $error("stray data write");
    a_busy_on: assert property (p_busy_on) else $error("busy missing");
    a_busy_off: assert property (p_busy_off) else $error("busy stray");
    a_readback: assert property (p_readback) else $error("control readback");
    a_lock_order: assert property (p_lock_order) else $error("lock levels");
    a_lock_hold: assert property (p_lock_hold) else $error("lock changed");
    a_reset_lock: assert property (p_reset_lock) else $error("lock reset");
endmodule

bind fpc_top fpc_props #(
    .ERASE_CYC(ERASE_CYC),
    .PROG_CYC (PROG_CYC)
) u_fpc_props (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dmem_we(dmem_we),
    .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .pp_lock_load(pp_lock_load),
    .pp_lock_bits(pp_lock_bits), .pp_prog_disable(pp_prog_disable),
    .pp_verify_disable(pp_verify_disable)
);

// ---- tb/test_flash_program_control.sv ----
`timescale 1ns/100ps
`include "fpc_cfg.svh"

module test_flash_program_control;
    logic        clk;
    logic        nrst;
    logic [11:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic        pp_lock_load;
    logic [2:0]  pp_lock_bits;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        dmem_we;
    logic [15:0] dmem_addr;
    logic [7:0]  dmem_wdata;
    logic        pp_prog_disable;
    logic        pp_verify_disable;
    logic [3:0]  be;
    logic [31:0] q;
    int          err_total;
    int          comparisons;
    int          pulses;

    // Shorter erase and program phases keep the run brief.
    fpc_top #(.ERASE_CYC(140), .PROG_CYC(140)) u_fpc_top (
        .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dmem_we(dmem_we),
        .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .pp_lock_load(pp_lock_load),
        .pp_lock_bits(pp_lock_bits), .pp_prog_disable(pp_prog_disable),
        .pp_verify_disable(pp_verify_disable)
    );

    // Free-running clock and a count of data-space write pulses.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (dmem_we === 1'b1)
            pulses <= pulses + 1;
    end

    ////////////////////////////////////////////////////////////
    // Shared bus and compare tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // The request is held until waitrequest is seen low; only the watchdog ends a wait.
    task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d);
        @(posedge clk);
        avs_address <= {i, 2'h0};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        bus(1'b1, i, d);
    endtask
    task automatic rd(input logic [9:0] i);
        bus(1'b0, i, 32'h0);
    endtask
    task automatic cread(input logic [15:0] a);
        wr(`FPC_IDX_CODE_READ, {16'h0, a});
        rd(`FPC_IDX_CODE_READ);
        q = q & 32'hff;
    endtask
    task automatic bsy(input logic e);
        rd(`FPC_IDX_CONTROL);
        chk({31'h0, q[0]}, {31'h0, e});
    endtask
    task automatic launch(input logic [3:0] lo);
        wr(`FPC_IDX_CONTROL, {24'h0, 4'h5, lo});
        wr(`FPC_IDX_CONTROL, {24'h0, 4'ha, lo});
    endtask
    task automatic idle;
        for (int k = 0; k < 200; k++) begin
            rd(`FPC_IDX_CONTROL);
            if (q[0] === 1'b0)
                break;
        end
        chk({31'h0, q[0]}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset;
        rd(`FPC_IDX_LOCK_STATUS);
        chk(q, 32'h1d);
        rd(`FPC_IDX_CONTROL);
        chk(q, 32'h0);
        rd(10'h0ff);
        chk(q, 32'h0);
    endtask

    // Every protection level through the parallel strobe, ending at level 3.
    task automatic t_lock;
        logic [2:0]  lb [4] = '{3'h7, 3'h6, 3'h3, 3'h5};
        logic [31:0] le [4] = '{32'h07, 32'h0e, 32'h1b, 32'h1d};
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            pp_lock_bits <= lb[k];
            @(posedge clk);
            pp_lock_load <= 1'b1;
            repeat (4) @(posedge clk);
            pp_lock_load <= 1'b0;
            repeat (12) @(posedge clk);
            rd(`FPC_IDX_LOCK_STATUS);
            chk(q, le[k]);
        end
    endtask

    // Two launches on neighbouring bytes: the second must not erase the first.
    task automatic t_user;
        wr(`FPC_IDX_CONTROL, 32'h08);
        wr(`FPC_IDX_DATA_WRITE, 32'h0000853c);
        launch(4'h0);
        bsy(1'b1);
        idle();
        cread(16'h0085);
        chk(q, 32'h3c);
        wr(`FPC_IDX_CONTROL, 32'h08);
        wr(`FPC_IDX_DATA_WRITE, 32'h000086c3);
        launch(4'h0);
        idle();
        cread(16'h0086);
        chk(q, 32'hc3);
        cread(16'h0085);
        chk(q, 32'h3c);
    endtask

    task automatic t_extra_row_space;
        wr(`FPC_IDX_CONTROL, 32'h0a);
        wr(`FPC_IDX_DATA_WRITE, 32'h00ff835a);
        launch(4'h2);
        bsy(1'b1);
        cread(16'h0085);
        chk(q, 32'h3c);
        idle();
        wr(`FPC_IDX_CONTROL, 32'h02);
        cread(16'hff83);
        chk(q, 32'h5a);
        cread(16'h0085);
        chk(q, 32'h3c);
        wr(`FPC_IDX_CONTROL, 32'h00);
        rd(`FPC_IDX_CONTROL);
        chk(q, 32'h0);
    endtask

    // Only the upper five bits of the byte take the new value; lock bits stay.
    task automatic t_sec;
        wr(`FPC_IDX_CONTROL, 32'h0c);
        wr(`FPC_IDX_DATA_WRITE, 32'h00000047);
        launch(4'h4);
        idle();
        wr(`FPC_IDX_CONTROL, 32'h04);
        cread(16'h0000);
        chk(q, 32'h45);
        rd(`FPC_IDX_LOCK_STATUS);
        chk(q, 32'h1d);
        wr(`FPC_IDX_CONTROL, 32'h00);
    endtask

    task automatic t_abort;
        be = 4'h0;
        wr(`FPC_IDX_CONTROL, 32'h08);
        be = 4'hf;
        rd(`FPC_IDX_CONTROL);
        chk(q, 32'h0);
        wr(`FPC_IDX_CONTROL, 32'h50);
        rd(`FPC_IDX_CONTROL);
        wr(`FPC_IDX_CONTROL, 32'ha0);
        bsy(1'b0);
        launch(4'h6);
        bsy(1'b0);
        wr(`FPC_IDX_CONTROL, 32'h01);
        bsy(1'b0);
    endtask

    task automatic t_dmem;
        int p;
        wr(`FPC_IDX_CONTROL, 32'h00);
        p = pulses;
        wr(`FPC_IDX_DATA_WRITE, 32'h00123499);
        repeat (2) @(posedge clk);
        chk(32'(pulses - p), 32'h1);
        chk({16'h0, dmem_addr, dmem_wdata}, 32'h00123499);
        wr(`FPC_IDX_CONTROL, 32'h08);
        p = pulses;
        wr(`FPC_IDX_DATA_WRITE, 32'h00000011);
        repeat (2) @(posedge clk);
        chk(32'(pulses - p), 32'h0);
        wr(`FPC_IDX_CONTROL, 32'h00);
    endtask

    ////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog.
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        pp_lock_load = 1'b0;
        pp_lock_bits = 3'h5;
        be = 4'hf;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_user();
        t_extra_row_space();
        t_sec();
        t_abort();
        t_dmem();
        t_lock();
        summarize();
    end

    // About four launches of under 400 cycles each fit easily in this span.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
endmodule
